// ### verilog/pcds_pkg.sv
// constants, register map and carriers for the point/character display sequencer
// assumes one 125 MHz clock shared by the apb slave and the processor strobes
package pcds_pkg;
	// clock rate and documented times (ns)
	localparam int CLK_MHZ       = 125;
	localparam int SETTLE_NS     = 25000;
	localparam int MOVE_NS       = 1500;
	localparam int MOVE_SLOW_NS  = 7000;
	localparam int MOVE_SHORT_NS = 500;
	localparam int INT_MIN_NS    = 500;
	localparam int INT_MAX_NS    = 10000;
	localparam int UPDATE_NS     = 8000;
	// least times round up, the longest pulse width rounds down
	localparam int SETTLE_CYC    = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int MOVE_CYC      = (MOVE_NS * CLK_MHZ + 999) / 1000;
	localparam int MOVE_SLOW_CYC = (MOVE_SLOW_NS * CLK_MHZ + 999) / 1000;
	localparam int MOVE_SHRT_CYC = (MOVE_SHORT_NS * CLK_MHZ + 999) / 1000;
	localparam int INT_MIN_CYC   = (INT_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int INT_MAX_CYC   = (INT_MAX_NS * CLK_MHZ) / 1000;
	localparam int UPDATE_CYC    = (UPDATE_NS * CLK_MHZ + 999) / 1000;
	// apb register byte offsets
	localparam logic [11:0] CTRL_OFS  = 12'h000;
	localparam logic [11:0] STAT_OFS  = 12'h004;
	localparam logic [11:0] COORD_OFS = 12'h008;
	// ctrl fields
	localparam int CTRL_SLOW_BIT = 0;
	localparam int CTRL_NEG_BIT  = 1;
	localparam int CTRL_WID_LSB  = 16;
	localparam logic [11:0] WIDTH_RST = 12'(INT_MIN_CYC);
	// status and coordinate fields
	localparam int STAT_ACT_BIT  = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_PAUS_BIT = 2;
	localparam int STAT_SIZE_BIT = 3;
	localparam int STAT_PAT_LSB  = 16;
	localparam int COORD_V_LSB   = 16;
	localparam int COORD_CH_BIT  = 31;
	// character geometry offsets
	localparam logic [4:0]  FULL_V_SPACE = 5'h18;
	localparam logic [4:0]  HALF_V_SPACE = 5'h0c;
	localparam logic [11:0] FULL_H_ADV   = 12'h008;
	localparam logic [11:0] HALF_H_ADV   = 12'h004;
	localparam logic [8:0]  FULL_V_STEP  = 9'h004;
	localparam logic [8:0]  HALF_V_STEP  = 9'h002;
	localparam logic [11:0] POINT_PAT    = 12'h0001;
	localparam logic [11:0] HORIZ_LOC    = 12'h0001;
	localparam int SIZE_AC_BIT = 7;
	localparam int OFS_A_BIT   = 2;
	localparam int OFS_B_BIT   = 1;
	// processor strobes and data into the sequencer
	typedef struct packed {
		logic        exec1_ts3;
		logic        exec1_ts5;
		logic        exec2_t1;
		logic        exec2_t2;
		logic        exec2_t3;
		logic        exec2_ts5;
		logic        point_ts5;
		logic        is_char;
		logic        special_functions_instr;
		logic [11:0] mb;
		logic [11:0] ac;
	} pcds_cpu_req_t;
	// answers back to the processor
	typedef struct packed {
		logic        pause;
		logic        mem_rd;
		logic [11:0] mem_addr;
		logic        ac_wr;
		logic [11:0] ac_data;
		logic        mb_wr;
		logic [11:0] mb_data;
	} pcds_cpu_rsp_t;
	// deflection and intensify outputs
	typedef struct packed {
		logic       chan;
		logic [8:0] horiz;
		logic [8:0] vert;
		logic       inten;
	} pcds_disp_t;
	// sequencer states
	typedef enum logic [2:0] {ST_IDLE, ST_SETTLE, ST_MOVE, ST_INTEN, ST_UPDATE} pcds_state_t;
endpackage

// ### verilog/pcds_top.sv
// point/character display sequencer: setup from processor strobes, timed plot loop
// assumes processor strobes are one-cycle pulses synchronous to pclk
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pcds_top
	import pcds_pkg::*;
(
	// clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// apb slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [11:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// processor side
	input  wire pcds_cpu_req_t cpu_req,
	output pcds_cpu_rsp_t      cpu_rsp,
	// deflection side
	output pcds_disp_t         disp
);
	localparam int SETTLE_I = SETTLE_CYC;
	localparam int UPD_I    = UPDATE_CYC;

	pcds_state_t state_q;          // sequencer state
	logic [11:0] cnt_q;            // interval down counter
	logic        active_q;         // display_active_flag
	logic        size_q;           // char_size_flag, 1 = full size
	logic [11:0] pat_q;            // intensity shift register, bit 0 is next dot
	logic [8:0]  horiz_q;          // horizontal_coord_reg
	logic [8:0]  vert_q;           // vertical_coord_reg
	logic        chan_q;           // channel select
	logic        inten_q;          // intensify_pulse pin level
	logic        pause_q;          // internal pause to the processor
	logic        slow_q;           // point_rate_switch
	logic        neg_q;            // intensify polarity, 1 = negative going
	logic [11:0] width_q;          // intensify width in cycles
	pcds_cpu_rsp_t rsp_q;          // registered processor answers
	logic [31:0] prdata_q;         // apb read data
	logic        pready_q;         // apb ready
	logic        pslverr_q;        // apb error
	logic        setup_done;       // last setup ts5 of either instruction
	logic        in_progress;      // display_in_progress
	logic        shift_pulse;      // pattern_shift_pulse
	logic [11:0] width_c;          // clamped width
	logic [11:0] new_pat;          // pattern after shift

	// move time depends on the dot about to be shown
	function automatic logic [11:0] move_len(input logic dot, input logic slow);
		if (!dot) begin
			return 12'(MOVE_SHRT_CYC);
		end else if (slow) begin
			return 12'(MOVE_SLOW_CYC);
		end else begin
			return 12'(MOVE_CYC);
		end
	endfunction

	// apb address decode
	function automatic logic known_ofs(input logic [11:0] a);
		return (a == CTRL_OFS) || (a == STAT_OFS) || (a == COORD_OFS);
	endfunction

	assign setup_done  = (cpu_req.exec2_ts5 && cpu_req.is_char) ||
	                     (cpu_req.point_ts5 && !cpu_req.is_char);
	assign in_progress = active_q || (state_q != ST_IDLE);
	assign shift_pulse = (state_q == ST_INTEN) && (cnt_q == 12'h000);
	assign new_pat     = {1'b0, pat_q[11:1]};
	// width knob held inside its documented span
	assign width_c = (width_q < 12'(INT_MIN_CYC)) ? 12'(INT_MIN_CYC) :
	                 (width_q > 12'(INT_MAX_CYC)) ? 12'(INT_MAX_CYC) : width_q;

	// apb slave: one wait state, answers from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else if (psel && penable && !pready_q) begin
			pready_q  <= 1'b1;
			pslverr_q <= !known_ofs(paddr);
			prdata_q  <= 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					CTRL_OFS: begin
						prdata_q[CTRL_SLOW_BIT] <= slow_q;
						prdata_q[CTRL_NEG_BIT]  <= neg_q;
						prdata_q[CTRL_WID_LSB +: 12] <= width_c; // the width in force
					end
					STAT_OFS: begin
						prdata_q[STAT_ACT_BIT]  <= active_q;
						prdata_q[STAT_BUSY_BIT] <= in_progress;
						prdata_q[STAT_PAUS_BIT] <= pause_q;
						prdata_q[STAT_SIZE_BIT] <= size_q;
						prdata_q[STAT_PAT_LSB +: 12] <= pat_q;
					end
					COORD_OFS: begin
						prdata_q[8:0] <= horiz_q;
						prdata_q[COORD_V_LSB +: 9] <= vert_q;
						prdata_q[COORD_CH_BIT] <= chan_q;
					end
					default: begin
						prdata_q <= 32'h0000_0000; // unmapped reads zero, with error
					end
				endcase
			end
		end else begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// control register write, taken at the first access edge, one edge before the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_q  <= 1'b0;
			neg_q   <= 1'b0;
			width_q <= WIDTH_RST;
		end else if (psel && penable && !pready_q && pwrite && paddr == CTRL_OFS) begin
			slow_q  <= pwdata[CTRL_SLOW_BIT];
			neg_q   <= pwdata[CTRL_NEG_BIT];
			width_q <= pwdata[CTRL_WID_LSB +: 12];
		end
	end

	// size flag from the special-functions instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			size_q <= 1'b0;
		end else if (cpu_req.special_functions_instr) begin
			size_q <= cpu_req.ac[SIZE_AC_BIT];
		end
	end

	// internal pause: taken at ts3, held until the old display ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pause_q <= 1'b0;
		end else if (cpu_req.exec1_ts3 && in_progress) begin
			pause_q <= 1'b1;
		end else if (!in_progress) begin
			pause_q <= 1'b0;
		end
	end

	// processor answers: location read, ac and mb rewrites
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_q <= '0;
		end else begin
			rsp_q.pause  <= 1'b0;
			rsp_q.mem_rd <= cpu_req.exec2_t1 && cpu_req.is_char;
			rsp_q.ac_wr  <= cpu_req.exec2_t2 && cpu_req.is_char;
			rsp_q.mb_wr  <= cpu_req.exec2_t3 && cpu_req.is_char;
			if (cpu_req.exec2_t1) begin
				rsp_q.mem_addr <= HORIZ_LOC;
			end
			if (cpu_req.exec2_t2) begin
				// spacing keeps characters on one line
				rsp_q.ac_data <= {cpu_req.ac[11:5], size_q ? FULL_V_SPACE : HALF_V_SPACE};
			end
			if (cpu_req.exec2_t3) begin
				rsp_q.mb_data <= cpu_req.mb + (size_q ? FULL_H_ADV : HALF_H_ADV);
			end
		end
	end

	// pattern register: loaded at setup, shifted each update
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pat_q <= 12'h000;
		end else if (cpu_req.exec1_ts5 && cpu_req.is_char && !pause_q) begin
			pat_q <= cpu_req.mb;
		end else if (cpu_req.point_ts5 && !cpu_req.is_char && !pause_q) begin
			pat_q <= POINT_PAT;
		end else if (shift_pulse) begin
			pat_q <= new_pat;
		end
	end

	// coordinate registers driving the converters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			horiz_q <= 9'h000;
			vert_q  <= 9'h000;
			chan_q  <= 1'b0;
		end else if (cpu_req.point_ts5 && !cpu_req.is_char && !pause_q) begin
			chan_q  <= cpu_req.mb[11];
			horiz_q <= cpu_req.mb[8:0];
			horiz_q[OFS_A_BIT] <= 1'b1;
			horiz_q[OFS_B_BIT] <= 1'b0;
			vert_q  <= cpu_req.ac[8:0];
		end else if (cpu_req.exec2_ts5 && cpu_req.is_char) begin
			horiz_q <= cpu_req.mb[8:0];
			// full size clears five low bits, half size four
			vert_q  <= size_q ? {cpu_req.ac[8:5], 5'h00} : {cpu_req.ac[8:4], 4'h0};
		end else if (shift_pulse) begin
			horiz_q[OFS_A_BIT] <= !horiz_q[OFS_A_BIT];
			if (!size_q) begin
				horiz_q[OFS_B_BIT] <= !horiz_q[OFS_B_BIT];
			end
			// a left dot shares the row of the previous right dot
			if (!horiz_q[OFS_A_BIT]) begin
				vert_q <= vert_q + (size_q ? FULL_V_STEP : HALF_V_STEP);
			end
		end
	end

	// active flag: set at end of setup, cleared at the end of the update interval once the pattern is empty
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_q <= 1'b0;
		end else if (setup_done && !pause_q) begin
			active_q <= 1'b1;
		end else if (state_q == ST_UPDATE && cnt_q == 12'h000 && pat_q == 12'h000) begin
			active_q <= 1'b0;
		end
	end

	// timed loop: settle, move, intensify, update
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			cnt_q   <= 12'h000;
		end else if (setup_done && !pause_q) begin
			state_q <= ST_SETTLE;
			cnt_q   <= 12'(SETTLE_CYC - 1);
		end else begin
			case (state_q)
				ST_IDLE: begin
					cnt_q <= 12'h000;
				end
				ST_SETTLE: begin
					if (cnt_q != 12'h000) begin
						cnt_q <= cnt_q - 12'h001;
					end else if (active_q) begin
						state_q <= ST_MOVE;
						cnt_q   <= move_len(pat_q[0], slow_q) - 12'h001;
					end
				end
				ST_MOVE: begin
					if (cnt_q != 12'h000) begin
						cnt_q <= cnt_q - 12'h001;
					end else begin
						state_q <= ST_INTEN;
						cnt_q   <= width_c - 12'h001;
					end
				end
				ST_INTEN: begin
					if (cnt_q != 12'h000) begin
						cnt_q <= cnt_q - 12'h001;
					end else begin
						state_q <= ST_UPDATE;
						cnt_q   <= 12'(UPDATE_CYC - 1);
					end
				end
				ST_UPDATE: begin
					if (cnt_q != 12'h000) begin
						cnt_q <= cnt_q - 12'h001;
					end else if (pat_q != 12'h000) begin
						state_q <= ST_MOVE;
						cnt_q   <= move_len(pat_q[0], slow_q) - 12'h001;
					end else begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// intensify pin: active level only for a set dot, idle level otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inten_q <= 1'b0;
		end else begin
			inten_q <= neg_q ^ (state_q == ST_INTEN && pat_q[0]);
		end
	end

	// output assembly straight from flops
	always_comb begin
		cpu_rsp       = rsp_q;
		cpu_rsp.pause = pause_q;
		disp.chan     = chan_q;
		disp.horiz    = horiz_q;
		disp.vert     = vert_q;
		disp.inten    = inten_q;
	end
	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// checks next to the logic they guard
	sequence upd_enter_s;
		state_q == ST_INTEN && cnt_q == 12'h000;
	endsequence
	sequence upd_run_s;
		(state_q == ST_UPDATE) [*8];
	endsequence

	// checker helpers: dwell in settle and update, counted apart from cnt_q
	logic [11:0] settle_run_q;     // cycles spent in settle since the last setup
	logic [11:0] upd_run_q;        // cycles spent in the current update interval
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_run_q <= 12'h000;
			upd_run_q    <= 12'h000;
		end else begin
			settle_run_q <= (state_q == ST_SETTLE && !(setup_done && !pause_q)) ?
			                settle_run_q + 12'h001 : 12'h000;
			upd_run_q    <= (state_q == ST_UPDATE) ? upd_run_q + 12'h001 : 12'h000;
		end
	end

	pause_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		pause_q && in_progress |=> pause_q)
		else $error("pause dropped while display busy");
	pause_rel_a: assert property (@(posedge pclk) disable iff (!presetn)
		pause_q && !in_progress && !cpu_req.exec1_ts3 |=> !pause_q)
		else $error("pause not released after display end");
	pattern_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_req.exec1_ts5 && cpu_req.is_char && !pause_q && !setup_done
		|=> pat_q == $past(cpu_req.mb) && active_q == $past(active_q))
		else $error("pattern load wrong");
	ac_space_a: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_req.exec2_t2 && cpu_req.is_char |=> rsp_q.ac_wr &&
		rsp_q.ac_data[4:0] == ($past(size_q) ? FULL_V_SPACE : HALF_V_SPACE))
		else $error("line spacing wrong");
	mb_advance_a: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_req.exec2_t3 && cpu_req.is_char |=> rsp_q.mb_wr &&
		rsp_q.mb_data == $past(cpu_req.mb) + ($past(size_q) ? FULL_H_ADV : HALF_H_ADV))
		else $error("horizontal advance wrong");
	settle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_SETTLE && cnt_q != 12'h000 && !setup_done |=> state_q == ST_SETTLE)
		else $error("settle delay cut short");
	settle_span_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_SETTLE && !setup_done
		|=> (state_q == ST_MOVE) == ($past(settle_run_q) == 12'(SETTLE_I - 1) && $past(active_q)))
		else $error("point clock did not start after settle");
	shift_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		upd_enter_s |=> (pat_q == {1'b0, $past(pat_q[11:1])}) and upd_run_s)
		else $error("shift or update interval wrong");
	upd_len_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_UPDATE && !setup_done
		|=> (state_q == ST_UPDATE) == ($past(upd_run_q) != 12'(UPD_I - 1)))
		else $error("update interval length wrong");
	vert_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		shift_pulse && !horiz_q[OFS_A_BIT] && !setup_done
		|=> vert_q == $past(vert_q) + ($past(size_q) ? FULL_V_STEP : HALF_V_STEP))
		else $error("vertical step wrong");
	done_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_UPDATE && cnt_q == 12'h000 && pat_q == 12'h000 && !setup_done
		|=> !active_q && state_q == ST_IDLE)
		else $error("display did not end on empty pattern");
	inten_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q != ST_INTEN || !pat_q[0] |=> inten_q == $past(neg_q))
		else $error("intensify outside its interval");
endmodule
`default_nettype wire

// ### dv/pcds_cpu_model.sv
// processor model: issues setup strobes, answers location reads
// assumes the sequencer cpu port and a single pclk domain
`timescale 1ns/1ps
`default_nettype none
module pcds_cpu_model
	import pcds_pkg::*;
(
	// clock
	input  wire logic          clk,
	// sequencer port
	output var pcds_cpu_req_t  req,
	input  wire pcds_cpu_rsp_t rsp
);
	logic [6:0]  st_q;   // setup strobes in field order
	logic        ch_q;   // char rather than point
	logic        esf_q;  // special functions strobe
	logic [11:0] mb_q;   // memory buffer
	logic [11:0] ac_q;   // accumulator
	logic [11:0] loc1_q; // memory location one
	logic [11:0] addr_q; // last address read
	logic [11:0] acw_q;  // last accumulator rewrite
	logic [11:0] mbw_q;  // last buffer rewrite
	int          pz;     // cycles held paused
	assign req = {st_q, ch_q, esf_q, mb_q, ac_q};
	// idle processor from time zero
	initial begin
		{st_q, ch_q, esf_q, mb_q, ac_q, loc1_q} = '0;
		pz = 0;
	end
	// write-backs from the sequencer land in the processor registers
	always @(posedge clk) begin
		if (rsp.mem_rd) begin
			mb_q   <= loc1_q;
			addr_q <= rsp.mem_addr;
		end
		if (rsp.ac_wr) begin
			ac_q  <= rsp.ac_data;
			acw_q <= rsp.ac_data;
		end
		if (rsp.mb_wr) begin
			mb_q  <= rsp.mb_data;
			mbw_q <= rsp.mb_data;
		end
	end
	// one strobe for one cycle, then a gap so answers can land
	task automatic pulse(input logic [6:0] s, input logic e);
		@(posedge clk);
		st_q  <= s;
		esf_q <= e;
		@(posedge clk);
		st_q  <= '0;
		esf_q <= 1'b0;
		@(posedge clk);
	endtask
	// opening time state, then stay in ts5 while paused
	task automatic enter(input logic c);
		ch_q <= c;
		pulse(7'h40, 1'b0);
		@(posedge clk);
		pz = 0;
		while (rsp.pause) begin
			@(posedge clk);
			pz++;
		end
	endtask
	// size flag from the accumulator
	task automatic size(input logic s);
		ac_q <= 12'(s) << SIZE_AC_BIT;
		pulse(7'h00, 1'b1);
	endtask
	// single point: returns at once, no wait for the display
	task automatic point(input logic [11:0] mb, input logic [11:0] ac);
		enter(1'b0);
		mb_q <= mb;
		ac_q <= ac;
		pulse(7'h01, 1'b0);
	endtask
	// character: pattern, location read, two rewrites, final setup
	task automatic chr(input logic [11:0] pat, input logic [11:0] loc, input logic [11:0] ac);
		enter(1'b1);
		mb_q   <= pat;
		ac_q   <= ac;
		loc1_q <= loc;
		pulse(7'h20, 1'b0);
		pulse(7'h10, 1'b0);
		pulse(7'h08, 1'b0);
		pulse(7'h04, 1'b0);
		pulse(7'h02, 1'b0);
	endtask
endmodule
`default_nettype wire

// ### dv/point_char_display_sequencer_bench.sv
// self-checking bench for the display sequencer
// assumes the processor model file and the design package
`timescale 1ns/1ps
`default_nettype none
module point_char_display_sequencer_bench
	import pcds_pkg::*;
;
	typedef struct {
		logic        ch, sz, slow, neg, busy;
		logic [11:0] pat, loc, ac, wid;
	} pcds_row_t;
	typedef struct {
		logic [11:0] a;
		logic [31:0] d, r;
		logic        w, e;
	} pcds_reg_t;
	// display rows; loc is location one for chars, the buffer for points
	pcds_row_t rows [5] = '{
		'{1, 1, 0, 0, 0, 12'h093f, 12'h0040, 12'h01a5, 12'h003f},
		'{1, 0, 1, 1, 0, 12'h0002, 12'h01f0, 12'h00c3, 12'h04e2},
		'{0, 1, 0, 0, 0, 12'h0001, 12'h08a5, 12'h00f0, 12'h003f},
		'{0, 0, 1, 1, 0, 12'h0001, 12'h0133, 12'h01ff, 12'h0100},
		'{1, 1, 0, 0, 1, 12'h0005, 12'h0100, 12'h0040, 12'h003f}};
	// register cases: reset values, read-only, unmapped, width clamps
	pcds_reg_t regs [7] = '{
		'{CTRL_OFS, 32'h0, 32'h003f_0000, 0, 0}, '{STAT_OFS, 32'h0, 32'h0, 0, 0},
		'{COORD_OFS, 32'h0, 32'h0, 0, 0}, '{STAT_OFS, 32'hffff_ffff, 32'h0, 1, 0},
		'{12'h00c, 32'h1234_5678, 32'h0, 1, 1},
		'{CTRL_OFS, 32'h0005_0000, 32'h003f_0000, 1, 0},
		'{CTRL_OFS, 32'h0fff_0003, 32'h04e2_0003, 1, 0}};
	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0]   paddr, mp;
	logic [31:0]   pwdata, prdata, rd;
	logic [8:0]    h0, v0;
	logic          sz, neg_m, on, on_p;
	bit            arm, watch;
	pcds_cpu_req_t req;
	pcds_cpu_rsp_t rsp;
	pcds_disp_t    disp;
	int            error_cnt, check_count, cyc, t0, t_exp, ix, npulse, wcnt, wid;
	pcds_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_req(req), .cpu_rsp(rsp), .disp(disp));
	pcds_cpu_model cpu_u (.clk(pclk), .req(req), .rsp(rsp));
	// 125 MHz clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input int got, input int lo, input int hi);
		check_count++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("MISMATCH %0t count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask
	task automatic summarize;
		$display("mismatches %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// apb master: holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// expected spot after k pattern steps from the setup position
	function automatic logic [17:0] pos_at(input int k);
		logic [8:0] h, v;
		logic       b;
		h = h0;
		v = v0;
		for (int i = 0; i < k; i++) begin
			b = h[OFS_A_BIT];
			h[OFS_A_BIT] = !b;
			if (!sz) h[OFS_B_BIT] = !h[OFS_B_BIT];
			if (!b) v = v + (sz ? FULL_V_STEP : HALF_V_STEP);
		end
		return {h, v};
	endfunction
	// pulse monitor: start time of the first intensify pulse, width and position of every pulse
	always @(posedge pclk) begin
		cyc = cyc + 1;
		on = disp.inten ^ neg_m;
		if (req.exec2_ts5 || req.point_ts5) begin
			arm = watch;
			t0 = cyc;
			ix = 0;
			npulse = 0;
		end
		if (arm && watch && on && !on_p) begin
			if (npulse == 0) chk_rng(cyc - t0, t_exp - 2, t_exp + 4);
			while (ix < 11 && mp[ix] !== 1'b1) ix++;
			chk({14'h0, disp.horiz, disp.vert}, {14'h0, pos_at(ix)});
			ix++;
			npulse++;
			wcnt = 0;
		end
		if (on) wcnt++;
		if (arm && watch && !on && on_p) chk_rng(wcnt, wid, wid);
		on_p = on;
	end
	// one display: set up, check write-backs and registers, wait for the end
	task automatic run(input pcds_row_t r);
		logic [11:0] acx, mbx;
		int          k;
		watch = 0;
		if (r.busy) cpu_u.chr(12'h0800, 12'h0100, 12'h0040);
		neg_m = r.neg;
		apb(1'b1, CTRL_OFS, {4'h0, r.wid, 14'h0, r.neg, r.slow}, rd, rerr);
		cpu_u.size(r.sz);
		acx = {r.ac[11:5], r.sz ? FULL_V_SPACE : HALF_V_SPACE};
		mbx = r.loc + (r.sz ? FULL_H_ADV : HALF_H_ADV);
		h0 = r.ch ? mbx[8:0] : {r.loc[8:3], 2'b10, r.loc[0]};
		v0 = r.ch ? acx[8:0] & (r.sz ? 9'h1e0 : 9'h1f0) : r.ac[8:0];
		mp = r.ch ? r.pat : POINT_PAT;
		sz = r.sz;
		wid = r.wid;
		k = 0;
		while (!mp[k]) k++;
		t_exp = SETTLE_CYC + k * (MOVE_SHRT_CYC + wid + UPDATE_CYC);
		t_exp += r.slow ? MOVE_SLOW_CYC : MOVE_CYC;
		watch = 1;
		if (r.ch) cpu_u.chr(r.pat, r.loc, r.ac);
		else cpu_u.point(r.loc, r.ac);
		chk_rng(cpu_u.pz, r.busy ? SETTLE_CYC : 0, r.busy ? 99999 : 0);
		if (r.ch) begin
			chk({20'h0, cpu_u.addr_q}, {20'h0, HORIZ_LOC});
			chk({20'h0, cpu_u.acw_q}, {20'h0, acx});
			chk({20'h0, cpu_u.mbw_q}, {20'h0, mbx});
		end
		apb(1'b0, STAT_OFS, 32'h0, rd, rerr);
		chk({30'h0, rd[STAT_SIZE_BIT], rd[STAT_ACT_BIT]}, {30'h0, r.sz, 1'b1});
		apb(1'b0, COORD_OFS, 32'h0, rd, rerr);
		chk({r.ch ? 1'b0 : rd[31], rd[30:0]},
			{r.ch ? 1'b0 : r.loc[11], 6'h0, v0, 7'h0, h0});
		do apb(1'b0, STAT_OFS, 32'h0, rd, rerr); while (rd[STAT_ACT_BIT] !== 1'b0);
		chk(32'(npulse), 32'($countones(mp)));
	endtask
	// watchdog, well past the expected run length
	initial begin
		repeat (90000) @(posedge pclk);
		error_cnt++;
		$display("MISMATCH %0t watchdog expired", $time);
		summarize();
	end
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, neg_m, on_p} = '0;
		{error_cnt, check_count, cyc, wcnt, wid} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) run(rows[i]);
		// reset in the middle of a display leaves everything idle
		watch = 0;
		cpu_u.point(12'h0010, 12'h0010);
		repeat (40) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({30'h0, rsp.pause, disp.inten}, 32'h0);
		presetn <= 1'b1;
		neg_m = 1'b0;
		foreach (regs[i]) begin
			if (regs[i].w) begin
				apb(1'b1, regs[i].a, regs[i].d, rd, rerr);
				chk({31'h0, rerr}, {31'h0, regs[i].e});
			end
			apb(1'b0, regs[i].a, 32'h0, rd, rerr);
			chk(rd, regs[i].r);
			chk({31'h0, rerr}, {31'h0, regs[i].e});
		end
		summarize();
	end
endmodule
`default_nettype wire
